// ===== hw/csu_pkg.sv
// constants, types and helpers of the code security unit
// assumes a 16-bit word-addressed cpu memory bus with 22-bit addresses
package csu_pkg;
    localparam int          ADDR_W      = 22;
    localparam int          DATA_W      = 16;
    localparam int          KEY_W       = 128;
    localparam int          PWD_WORDS   = 8;
    localparam logic [21:0] KEY_BASE    = 22'h000ae0;
    localparam logic [21:0] KEY_LAST    = 22'h000ae7;
    localparam logic [21:0] STAT_ADDR   = 22'h000aef;
    localparam logic [21:0] PWD_BASE    = 22'h3f7ff8;
    localparam logic [21:0] PWD_LAST    = 22'h3f7fff;
    localparam logic [21:0] OTP_LO      = 22'h3d7800;
    localparam logic [21:0] OTP_HI      = 22'h3d7bff;
    localparam logic [21:0] FLASH_HI    = 22'h3f7fff;
    localparam logic [21:0] FLASH_LO    = 22'h3f0000;
    localparam logic [21:0] RAM_ZERO_LO = 22'h008000;
    localparam logic [21:0] RAM_ZERO_HI = 22'h0087ff;
    localparam logic [21:0] RAM_ONE_LO  = 22'h008800;
    localparam logic [21:0] RAM_ONE_HI  = 22'h008fff;
    localparam logic [4:0]  PWD_WAIT    = 5'h10;
    localparam logic [15:0] BLOCKED_VAL = 16'h0000;
    localparam logic [7:0]  ALL_READ    = 8'hff;

    typedef enum logic [1:0] {
        F_ADDR = 2'b00,
        F_WAIT = 2'b01,
        F_DONE = 2'b11
    } csu_fetch_type;

    typedef enum logic [1:0] {
        A_IDLE = 2'b00,
        A_MEM  = 2'b01,
        A_RESP = 2'b11
    } csu_acc_type;

    function automatic logic csu_in(input logic [21:0] a, input logic [21:0] lo,
                                    input logic [21:0] hi);
        csu_in = (a >= lo) && (a <= hi);
    endfunction
endpackage

// ===== hw/csu_pwd_fetch.sv
// reads the eight stored password words out of flash after reset
// assumes the flash read port returns data once the wait states have passed
`timescale 1ns/1ps
module csu_pwd_fetch (
    input  wire logic                ref_clk,
    input  wire logic                nrst,
    output logic                     pf_req_r,
    output logic [csu_pkg::ADDR_W-1:0] pf_addr_r,
    input  wire logic [csu_pkg::DATA_W-1:0] pf_rdata,
    output logic [csu_pkg::KEY_W-1:0]  pwd_r,
    output logic                     pwd_valid_r
);
    import csu_pkg::*;

    csu_fetch_type state_r;
    logic [2:0]    idx_r;
    logic [4:0]    wait_r;

    // wait count is fixed, never taken from the flash wait-state settings
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state_r  <= F_ADDR;
            idx_r    <= 3'h0;
            wait_r   <= 5'h00;
            pf_req_r <= 1'b0;
            pf_addr_r <= PWD_BASE;
        end else begin
            unique case (state_r)
                F_ADDR: begin
                    pf_req_r  <= 1'b1;
                    pf_addr_r <= PWD_BASE + {19'h0, idx_r};
                    wait_r    <= 5'h00;
                    state_r   <= F_WAIT;
                end
                F_WAIT: begin
                    pf_req_r <= 1'b0;
                    if (wait_r == PWD_WAIT) begin
                        idx_r   <= idx_r + 3'h1;
                        state_r <= (idx_r == 3'h7) ? F_DONE : F_ADDR;
                    end else begin
                        wait_r <= wait_r + 5'h01;
                    end
                end
                F_DONE: pf_req_r <= 1'b0;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pwd_r       <= '0;
            pwd_valid_r <= 1'b0;
        end else if (state_r == F_WAIT && wait_r == PWD_WAIT) begin
            pwd_r[idx_r*16 +: 16] <= pf_rdata;
            pwd_valid_r           <= (idx_r == 3'h7);
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    property p_pwd_ws;
        pf_req_r |=> !pf_req_r [*8] ##1 !pf_req_r [*8];
    endproperty
    a_pwd_ws: assert property (p_pwd_ws) else $error("password read spaced under 16 waits");

    property p_pwd_addr;
        pf_req_r |-> csu_in(pf_addr_r, PWD_BASE, PWD_LAST);
    endproperty
    a_pwd_addr: assert property (p_pwd_addr) else $error("password read outside its words");
endmodule

// ===== hw/csu_gate.sv
// code security gate between the cpu memory bus and the secure memories
// assumes one outstanding cpu request at a time and a secure memory that acks each request
`timescale 1ns/1ps
module csu_gate (
    input  wire logic                         ref_clk,
    input  wire logic                         nrst,
    input  wire logic                         cpu_req,
    input  wire logic                         cpu_we,
    input  wire logic                         cpu_fetch,
    input  wire logic                         cpu_dbg,
    input  wire logic                         cpu_from_secure,
    input  wire logic [csu_pkg::ADDR_W-1:0]   cpu_addr,
    input  wire logic [csu_pkg::DATA_W-1:0]   cpu_wdata,
    output logic                              cpu_ack_r,
    output logic [csu_pkg::DATA_W-1:0]        cpu_rdata_r,
    input  wire logic                         emu_attached,
    output logic                              emu_cut_r,
    output logic                              ext_fetch_block_r,
    output logic                              boot_load_block_r,
    output logic                              secure_unlocked_r,
    output logic                              sec_req_r,
    output logic                              sec_we_r,
    output logic [csu_pkg::ADDR_W-1:0]        sec_addr_r,
    output logic [csu_pkg::DATA_W-1:0]        sec_wdata_r,
    input  wire logic [csu_pkg::DATA_W-1:0]   sec_rdata,
    input  wire logic                         sec_ack,
    output logic                              pf_req_r,
    output logic [csu_pkg::ADDR_W-1:0]        pf_addr_r,
    input  wire logic [csu_pkg::DATA_W-1:0]   pf_rdata
);
    import csu_pkg::*;

    csu_acc_type        acc_r;
    logic [KEY_W-1:0]   key_r;
    logic [KEY_W-1:0]   pwd;
    logic               pwd_valid;
    logic [7:0]         rd_mask_r;
    logic               key_hit;
    logic               stat_hit;
    logic               sec_hit;
    logic               emu_zone;
    logic               pwd_hit;
    logic               take;
    logic               allowed;
    logic               pwd_zero;
    logic               pwd_ones;
    logic               low_ones;
    logic               full_match;
    logic               low_match;
    logic               emu_ok;
    logic               unlock_nxt;

    csu_pwd_fetch u_fetch (
        .ref_clk     (ref_clk),
        .nrst        (nrst),
        .pf_req_r    (pf_req_r),
        .pf_addr_r   (pf_addr_r),
        .pf_rdata    (pf_rdata),
        .pwd_r       (pwd),
        .pwd_valid_r (pwd_valid)
    );

    // one lock covers all four blocks; only the second ram block stays outside the emulation zone
    always_comb begin
        key_hit   = csu_in(cpu_addr, KEY_BASE, KEY_LAST);
        stat_hit  = (cpu_addr == STAT_ADDR);
        emu_zone  = csu_in(cpu_addr, FLASH_LO, FLASH_HI) || csu_in(cpu_addr, OTP_LO, OTP_HI)
                  || csu_in(cpu_addr, RAM_ZERO_LO, RAM_ZERO_HI);
        sec_hit   = emu_zone || csu_in(cpu_addr, RAM_ONE_LO, RAM_ONE_HI);
        pwd_hit   = csu_in(cpu_addr, PWD_BASE, PWD_LAST);
    end

    // secure accesses wait for the password, so nothing is judged on a stale lock
    assign take    = (acc_r == A_IDLE) && cpu_req && (pwd_valid || !sec_hit);
    // code running from the secure region may use it, debug and outside code may not
    assign allowed = secure_unlocked_r || (!cpu_dbg && cpu_from_secure);

    always_comb begin
        pwd_zero   = (pwd == '0);
        pwd_ones   = &pwd;
        low_ones   = &pwd[63:0];
        full_match = (key_r == pwd) && (rd_mask_r == ALL_READ);
        low_match  = (key_r[63:0] == pwd[63:0]) && (rd_mask_r == ALL_READ);
        // an all-zero password can never unlock, whatever key is written
        unlock_nxt = pwd_valid && !pwd_zero && (pwd_ones || full_match);
        emu_ok     = pwd_valid && !pwd_zero && (low_ones || low_match);
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            key_r <= '0;
        end else if (take && cpu_we && key_hit) begin
            key_r[cpu_addr[2:0]*16 +: 16] <= cpu_wdata;
        end
    end

    // password words read by software count even when the read itself is blocked
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rd_mask_r <= 8'h00;
        end else if (take && !cpu_we && pwd_hit) begin
            rd_mask_r[cpu_addr[2:0]] <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            secure_unlocked_r <= 1'b0;
            ext_fetch_block_r <= 1'b1;
            boot_load_block_r <= 1'b1;
        end else begin
            secure_unlocked_r <= unlock_nxt;
            ext_fetch_block_r <= !unlock_nxt;
            boot_load_block_r <= !unlock_nxt;
        end
    end

    // sticky until reset; no hold-in-reset input exists to attach a debugger
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            emu_cut_r <= 1'b0;
        end else if (take && emu_zone && emu_attached && !emu_ok) begin
            emu_cut_r <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            acc_r       <= A_IDLE;
            cpu_ack_r   <= 1'b0;
            cpu_rdata_r <= 16'h0000;
            sec_req_r   <= 1'b0;
            sec_we_r    <= 1'b0;
            sec_addr_r  <= '0;
            sec_wdata_r <= '0;
        end else begin
            unique case (acc_r)
                A_IDLE: begin
                    cpu_ack_r <= 1'b0;
                    if (take) begin
                        if (sec_hit && allowed) begin
                            sec_req_r   <= 1'b1;
                            sec_we_r    <= cpu_we;
                            sec_addr_r  <= cpu_addr;
                            sec_wdata_r <= cpu_wdata;
                            acc_r       <= A_MEM;
                        end else begin
                            cpu_ack_r <= 1'b1;
                            acc_r     <= A_RESP;
                            if (stat_hit && !cpu_we) begin
                                cpu_rdata_r <= {11'h000, cpu_fetch && 1'b0, emu_cut_r, pwd_zero,
                                                pwd_valid, secure_unlocked_r};
                            end else begin
                                // key words read back as zero; blocked reads too
                                cpu_rdata_r <= BLOCKED_VAL;
                            end
                        end
                    end
                end
                A_MEM: begin
                    sec_req_r <= 1'b0;
                    if (sec_ack) begin
                        cpu_ack_r   <= 1'b1;
                        cpu_rdata_r <= sec_we_r ? 16'h0000 : sec_rdata;
                        acc_r       <= A_RESP;
                    end
                end
                A_RESP: begin
                    cpu_ack_r <= 1'b0;
                    acc_r     <= A_IDLE;
                end
                default: acc_r <= A_IDLE;
            endcase
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence s_blocked_take;
        take && sec_hit && !allowed;
    endsequence
    sequence s_blocked_answer;
        cpu_ack_r && cpu_rdata_r == BLOCKED_VAL && !sec_req_r ##1 !cpu_ack_r;
    endsequence

    property p_block_read;
        s_blocked_take |=> s_blocked_answer;
    endproperty
    a_block_read: assert property (p_block_read) else $error("blocked access reached memory");

    property p_dbg_locked;
        take && cpu_dbg && sec_hit && !secure_unlocked_r |=> !sec_req_r [*2];
    endproperty
    a_dbg_locked: assert property (p_dbg_locked) else $error("debug read of locked memory");

    property p_ext_block;
        !secure_unlocked_r ##1 !secure_unlocked_r |-> ext_fetch_block_r && boot_load_block_r;
    endproperty
    a_ext_block: assert property (p_ext_block) else $error("external path open while locked");

    property p_unlock;
        $rose(secure_unlocked_r) |-> $past(unlock_nxt) && (rd_mask_r == ALL_READ || pwd_ones);
    endproperty
    a_unlock: assert property (p_unlock) else $error("unlock without key match");

    property p_allowed_pass;
        take && sec_hit && allowed |=> sec_req_r ##1 !sec_req_r;
    endproperty
    a_allowed_pass: assert property (p_allowed_pass) else $error("granted access not issued");

    property p_emu_trip;
        take && emu_zone && emu_attached && !emu_ok |=> emu_cut_r [*3];
    endproperty
    a_emu_trip: assert property (p_emu_trip) else $error("emulation link not cut");

    property p_emu_cause;
        $rose(emu_cut_r) |-> $past(!emu_ok && emu_attached);
    endproperty
    a_emu_cause: assert property (p_emu_cause) else $error("trip despite low key match");

    property p_low_ones;
        pwd_valid && low_ones && !pwd_zero |-> emu_ok;
    endproperty
    a_low_ones: assert property (p_low_ones) else $error("unprogrammed low half still trips");

    property p_zero_pwd;
        pwd_valid && pwd_zero |=> !secure_unlocked_r;
    endproperty
    a_zero_pwd: assert property (p_zero_pwd) else $error("zero password unlocked");

    property p_key_write;
        take && cpu_we && key_hit |=> key_r[$past(cpu_addr[2:0])*16 +: 16] == $past(cpu_wdata);
    endproperty
    a_key_write: assert property (p_key_write) else $error("key word not stored");
endmodule

// ===== sim/csu_far_model.sv
// far side of the security gate: secure memories and the flash password read port
// assumes the gate raises sec_req_r and pf_req_r as one-cycle pulses, one at a time
`timescale 1ns/1ps
module csu_far_model #(
    parameter logic [127:0] PWD = 128'h8888_7777_6666_5555_4444_3333_2222_1111
) (
    input  wire logic                        ref_clk,
    input  wire logic                        slow,
    input  wire logic                        sec_req_r,
    input  wire logic [csu_pkg::ADDR_W-1:0]  sec_addr_r,
    output logic                             sec_ack,
    output logic [csu_pkg::DATA_W-1:0]       sec_rdata,
    input  wire logic                        pf_req_r,
    input  wire logic [csu_pkg::ADDR_W-1:0]  pf_addr_r,
    output logic [csu_pkg::DATA_W-1:0]       pf_rdata
);
    import csu_pkg::*;
    int unsigned    pf_cnt  = 0;
    int unsigned    ack_cnt = 0;
    logic           busy    = 1'b0;
    logic [15:0]    pf_word = 16'h0000;
    logic [21:0]    a_hold  = 22'h000000;

    localparam logic [21:0] RSV_LO  = 22'h3f7f80;
    localparam logic [21:0] RSV_HI  = 22'h3f7ff5;
    localparam logic        PWD_SET = (PWD != '1);

    // a programmed password means the reserved words below it hold zero
    // with security unused they keep ordinary data; the bench fetches no code there
    function automatic logic [15:0] mem_word(input logic [21:0] a);
        if (PWD_SET && csu_in(a, RSV_LO, RSV_HI))
            mem_word = 16'h0000;
        else
            mem_word = a[15:0] ^ 16'h5a5a;
    endfunction

    initial begin
        sec_ack   = 1'b0;
        sec_rdata = 16'hffff;
        pf_rdata  = 16'hffff;
    end

    // word i of the top eight flash words carries key bits [16i+15:16i]
    always @(posedge ref_clk) begin
        if (pf_req_r) begin
            pf_word <= PWD[16*pf_addr_r[2:0] +: 16];
            pf_cnt  <= 1;
        end else if (pf_cnt != 0 && pf_cnt < 16) begin
            pf_cnt <= pf_cnt + 1;
        end
    end

    // the word only appears once the fixed wait has run; earlier the lines keep toggling
    always @(posedge ref_clk) begin
        if (!pf_req_r && pf_cnt == 15)
            pf_rdata <= pf_word;
        else if (pf_req_r || pf_cnt < 16)
            pf_rdata <= ~pf_rdata;
    end

    // reads return a pattern of the address; slow mode stalls the answer a few cycles
    always @(posedge ref_clk) begin
        sec_ack   <= 1'b0;
        sec_rdata <= ~sec_rdata;
        if (sec_req_r && !slow) begin
            sec_ack   <= 1'b1;
            sec_rdata <= mem_word(sec_addr_r);
        end else if (sec_req_r) begin
            busy    <= 1'b1;
            a_hold  <= sec_addr_r;
            ack_cnt <= 4;
        end else if (busy && ack_cnt == 0) begin
            busy      <= 1'b0;
            sec_ack   <= 1'b1;
            sec_rdata <= mem_word(a_hold);
        end else if (busy) begin
            ack_cnt <= ack_cnt - 1;
        end
    end
endmodule

// ===== sim/code_security_unit_tb.sv
// self-checking bench for the code security gate beside its far-side model
// assumes csu_pkg and the gate are compiled first; inputs change on the falling edge
`timescale 1ns/1ps
module code_security_unit_tb;
    import csu_pkg::*;
    localparam logic [127:0] PWD = 128'h8888_7777_6666_5555_4444_3333_2222_1111;
    typedef struct {
        logic        we, dbg, fsec, fetch;
        logic [21:0] addr;
        logic [15:0] wdata, exp;
        logic        grant;
    } csu_row_type;

    logic ref_clk = 1'b0, nrst = 1'b0, slow = 1'b0, emu_attached = 1'b0;
    logic cpu_req = 1'b0, cpu_we = 1'b0, cpu_fetch = 1'b0, cpu_dbg = 1'b0;
    logic cpu_from_secure = 1'b0;
    logic [21:0] cpu_addr = 22'h000000, sec_addr_r, pf_addr_r;
    logic [15:0] cpu_wdata = 16'h0000, cpu_rdata_r, sec_wdata_r, sec_rdata, pf_rdata;
    logic cpu_ack_r, emu_cut_r, ext_fetch_block_r, boot_load_block_r, secure_unlocked_r;
    logic sec_req_r, sec_we_r, sec_ack, pf_req_r;
    int   bad_count = 0, n_checks = 0, grants = 0, cycles = 0;

    // granted rows expect the model's address pattern; reserved words below the password read zero
    csu_row_type rows [9] = '{
        '{0, 0, 1, 0, 22'h008000, 16'h0000, 16'hda5a, 1},
        '{0, 0, 1, 1, 22'h3f0010, 16'h0000, 16'h5a4a, 1},
        '{0, 0, 1, 0, 22'h3f7f80, 16'h0000, 16'h0000, 1},
        '{0, 0, 0, 0, 22'h3d7800, 16'h0000, 16'h0000, 0},
        '{0, 1, 0, 0, 22'h008800, 16'h0000, 16'h0000, 0},
        '{1, 0, 0, 0, 22'h3f0020, 16'h1234, 16'h0000, 0},
        '{0, 0, 0, 0, 22'h000aef, 16'h0000, 16'h0002, 0},
        '{0, 0, 0, 0, 22'h000ae0, 16'h0000, 16'h0000, 0},
        '{0, 0, 0, 0, 22'h000100, 16'h0000, 16'h0000, 0}
    };

    csu_gate dut (.ref_clk, .nrst, .cpu_req, .cpu_we, .cpu_fetch, .cpu_dbg, .cpu_from_secure,
        .cpu_addr, .cpu_wdata, .cpu_ack_r, .cpu_rdata_r, .emu_attached, .emu_cut_r,
        .ext_fetch_block_r, .boot_load_block_r, .secure_unlocked_r, .sec_req_r, .sec_we_r,
        .sec_addr_r, .sec_wdata_r, .sec_rdata, .sec_ack, .pf_req_r, .pf_addr_r, .pf_rdata);
    csu_far_model #(.PWD(PWD)) far (.ref_clk, .slow, .sec_req_r, .sec_addr_r, .sec_ack,
        .sec_rdata, .pf_req_r, .pf_addr_r, .pf_rdata);

    always #5 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        if (sec_req_r === 1'b1)
            grants++;
        cycles++;
        if (cycles == 6000) begin
            bad_count++;
            $display("unexpected at %0t: run too long", $time);
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp, input string what);
        chk16({15'h0000, got}, {15'h0000, exp}, what);
    endtask

    task automatic do_reset();
        @(negedge ref_clk);
        nrst = 1'b0;
        repeat (5) @(negedge ref_clk);
        nrst = 1'b1;
    endtask

    // request held until the ack is seen, released on that same falling edge
    task automatic access(input logic we, dbg, fsec, fetch, input logic [21:0] addr,
                          input logic [15:0] wdata, output logic [15:0] rd, output int g);
        int n;
        int g0;
        n  = 0;
        g0 = grants;
        @(negedge ref_clk);
        {cpu_req, cpu_we, cpu_dbg, cpu_from_secure, cpu_fetch} = {1'b1, we, dbg, fsec, fetch};
        cpu_addr  = addr;
        cpu_wdata = wdata;
        do begin
            @(negedge ref_clk);
            n++;
        end while (cpu_ack_r !== 1'b1 && n < 400);
        if (n >= 400) begin
            bad_count++;
            $display("unexpected at %0t: no answer", $time);
        end
        rd      = cpu_rdata_r;
        g       = grants - g0;
        cpu_req = 1'b0;
    endtask

    initial begin
        logic [15:0] rd;
        int          g;
        do_reset();
        chk1(cpu_ack_r | sec_req_r, 1'b0, "bus idle at reset");
        chk1(ext_fetch_block_r & boot_load_block_r, 1'b1, "blocks at reset");
        chk1(secure_unlocked_r | emu_cut_r, 1'b0, "unlock or cut at reset");
        access(0, 0, 0, 0, STAT_ADDR, 16'h0000, rd, g);
        // the password register is still clear here, so its zero flag reads set
        chk16(rd, 16'h0004, "status before fetch");
        $display("test reset done");
        foreach (rows[i]) begin
            access(rows[i].we, rows[i].dbg, rows[i].fsec, rows[i].fetch, rows[i].addr,
                   rows[i].wdata, rd, g);
            chk16(rd, rows[i].exp, "row data");
            chk16(16'(g), {15'h0000, rows[i].grant}, "row grants");
        end
        $display("test table done");
        @(negedge ref_clk);
        emu_attached = 1'b1;
        access(0, 0, 1, 0, RAM_ONE_LO, 16'h0000, rd, g);
        chk1(emu_cut_r, 1'b0, "cut after ram one");
        access(0, 0, 1, 0, FLASH_LO, 16'h0000, rd, g);
        chk1(emu_cut_r, 1'b1, "cut after flash");
        access(0, 0, 0, 0, STAT_ADDR, 16'h0000, rd, g);
        chk16(rd, 16'h000a, "status with cut");
        emu_attached = 1'b0;
        do_reset();
        chk1(emu_cut_r, 1'b0, "cut after reset");
        $display("test trip done");
        for (int i = 0; i < 4; i++)
            access(1, 0, 0, 0, KEY_BASE + 22'(i), PWD[16*i +: 16], rd, g);
        // software dummy-reads every password word before debugging
        for (int i = 0; i < 8; i++) begin
            access(0, 0, 0, 0, PWD_BASE + 22'(i), 16'h0000, rd, g);
            chk16(rd, 16'h0000, "dummy read");
        end
        @(negedge ref_clk);
        emu_attached = 1'b1;
        access(0, 0, 1, 0, FLASH_LO, 16'h0000, rd, g);
        chk1(emu_cut_r, 1'b0, "cut with low key");
        access(0, 1, 0, 0, 22'h3f0040, 16'h0000, rd, g);
        chk16(rd, 16'h0000, "debug read with low key");
        $display("test low key done");
        slow = 1'b1;
        for (int i = 4; i < 8; i++)
            access(1, 0, 0, 0, KEY_BASE + 22'(i), PWD[16*i +: 16], rd, g);
        // the lock flop follows the key one edge after the write is answered
        @(negedge ref_clk);
        chk1(secure_unlocked_r, 1'b1, "unlock");
        chk1(ext_fetch_block_r | boot_load_block_r, 1'b0, "blocks after unlock");
        access(0, 0, 0, 0, STAT_ADDR, 16'h0000, rd, g);
        chk16(rd, 16'h0003, "status unlocked");
        access(0, 1, 0, 0, 22'h3f0040, 16'h0000, rd, g);
        chk16(rd, 16'h5a1a, "debug read unlocked");
        access(1, 0, 0, 0, KEY_LAST, 16'h0000, rd, g);
        @(negedge ref_clk);
        chk1(secure_unlocked_r, 1'b0, "relock");
        access(0, 1, 0, 0, 22'h3f0040, 16'h0000, rd, g);
        chk16(rd, 16'h0000, "debug read relocked");
        $display("test unlock done");
        finish_test();
    end
endmodule
